/* verilog/pms_pkg.sv */
// Package of constants, carrier structs and helpers for the management status register bank.
package pms_pkg;

  // Register addresses on the management register port.
  localparam logic [4:0] PMS_REG_STATUS = 5'h01;
  localparam logic [4:0] PMS_REG_DETAIL = 5'h11;

  // Bit positions in the basic link status register.
  localparam int PMS_B_T4     = 15;
  localparam int PMS_B_TX_FD  = 14;
  localparam int PMS_B_TX_HD  = 13;
  localparam int PMS_B_T_FD   = 12;
  localparam int PMS_B_T_HD   = 11;
  localparam int PMS_B_RSV_HI = 10;
  localparam int PMS_B_RSV_LO = 7;
  localparam int PMS_B_PRE    = 6;
  localparam int PMS_B_ANC    = 5;
  localparam int PMS_B_RF     = 4;
  localparam int PMS_B_ANA    = 3;
  localparam int PMS_B_LINK   = 2;
  localparam int PMS_B_JAB    = 1;
  localparam int PMS_B_EXT    = 0;

  // Bit positions of the mirrored flags in the detailed status register.
  localparam int PMS_D_LINK = 0;
  localparam int PMS_D_RF   = 1;
  localparam int PMS_D_JAB  = 2;

  // Fixed values of the constant bits.
  localparam logic PMS_T4_VAL  = 1'h0;
  localparam logic PMS_ANA_VAL = 1'h1;
  localparam logic PMS_EXT_VAL = 1'h1;
  localparam logic PMS_RSV_VAL = 1'h0;

  // Override-writable capability bits.
  typedef struct packed {
    logic tx_fd;
    logic tx_hd;
    logic t_fd;
    logic t_hd;
    logic pre_ok;
  } pms_caps_t;

  localparam pms_caps_t PMS_CAPS_RST = '{tx_fd: 1'h1, tx_hd: 1'h1, t_fd: 1'h1, t_hd: 1'h1, pre_ok: 1'h0};

  // One register access from the serial management frame engine.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pms_req_t;

  // Live conditions from the link monitor, negotiation engine, jabber timer and other registers.
  typedef struct packed {
    logic override_en;
    logic an_enable;
    logic an_done;
    logic lcw_valid;
    logic lcw_rf;
    logic link_valid;
    logic jabber_det;
    logic jabber_inhibit;
  } pms_evt_t;

  typedef struct packed {
    pms_caps_t   caps;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        partner_rf;
  } pms_main_st_t;

  typedef struct packed {
    logic flag;
  } pms_flag_st_t;

  // True when the request reads the given register.
  function automatic logic pms_reads(input pms_req_t req, input logic [4:0] addr);
    pms_reads = req.rd && (req.addr == addr);
  endfunction

  // True when the request writes the given register.
  function automatic logic pms_writes(input pms_req_t req, input logic [4:0] addr);
    pms_writes = req.wr && (req.addr == addr);
  endfunction

endpackage

/* verilog/pms_latch_flag.sv */
// Latching status flag that loads its follow value on read, with a forced clear.
`timescale 1ns/10ps

module pms_latch_flag
  import pms_pkg::*;
#(
  parameter logic SET_VAL = 1'h1,
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic event_live,
  input  wire logic follow,
  input  wire logic rd_clr,
  input  wire logic force_clr,
  output logic      flag_ff
);

  pms_flag_st_t st_ff;
  pms_flag_st_t nxt_st;

  // The event is checked before the read so that an event in the read cycle is kept.
  always_comb begin
    nxt_st = st_ff;
    if (force_clr) begin
      nxt_st.flag = 1'h0;
    end else if (event_live) begin
      nxt_st.flag = SET_VAL;
    end else if (rd_clr) begin
      nxt_st.flag = follow;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{flag: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag_ff = st_ff.flag;

  flag_set_wins_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!force_clr && event_live) |=> (flag_ff == SET_VAL))
    else $error("latched flag missed its event");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!force_clr && !event_live && !rd_clr) |=> $stable(flag_ff))
    else $error("latched flag changed without cause");

endmodule

/* verilog/pms_status_reg.sv */
// Basic link status register with latched flags and detailed-status mirrors of the link, remote fault and jabber flags.
`timescale 1ns/10ps

// Behaviour
// - Bit 12 ten-meg full duplex, resets one.
// - Bit 11 ten-meg half duplex, resets one.
// - Reserved bits 10..7 always read zero.
// - Override-writable bits change only when override set.
// - Bit 6 preamble-less frames accepted, resets zero.
// - Writing bit 6 enables preamble-less frame acceptance.
// - Negotiation disabled holds complete flag zero.
// - Complete flag sets only when negotiation finishes.
// - Complete flag latches; second read shows present.
// - Link code word remote fault sets bit 4.
// - Remote fault one bit, two views, read reloads the code word copy.
// - Non-latching remote fault copy per code word.
// - Bit 3 negotiation ability reads one.
// - Bit 2 link status latches low, mirrored.
// - Jabber inhibit zero forces jabber flag zero.
// - Jabber condition sets bit 1, else unchanged.
// - Jabber flag latches, two views, read clears.
// - Bit 15 four-pair mode always zero.
// - Bit 0 extended capability always one.
module pms_status_reg
  import pms_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire pms_req_t    req,
  input  wire pms_evt_t    evt,
  output logic [15:0]      rd_data_ff,
  output logic             rd_valid_ff,
  output logic [2:0]       detail_flags_ff,
  output logic             partner_rf_ff,
  output logic             preamble_ok_ff,
  output logic             an_complete_ff
);

  pms_main_st_t st_ff;
  pms_main_st_t nxt_st;

  logic rd_status;
  logic rd_detail;
  logic rd_clr;
  logic wr_status;
  logic anc_flag_ff;
  logic rf_flag_ff;
  logic link_flag_ff;
  logic jab_flag_ff;
  logic [15:0] status_word;

  assign rd_status = pms_reads(req, PMS_REG_STATUS);
  assign rd_detail = pms_reads(req, PMS_REG_DETAIL);
  assign wr_status = pms_writes(req, PMS_REG_STATUS);
  // A read of either register reloads the shared latched flags with their follow values (jabber clears to zero).
  assign rd_clr    = rd_status || rd_detail;

  // Negotiation complete: forced low while negotiation is off.
  pms_latch_flag #(
    .SET_VAL (1'h1),
    .RST_VAL (1'h0)
  ) u_anc (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .event_live (evt.an_enable && evt.an_done),
    .follow     (evt.an_enable && evt.an_done),
    .rd_clr     (rd_clr),
    .force_clr  (!evt.an_enable),
    .flag_ff    (anc_flag_ff)
  );

  // Remote fault: set by a received code word carrying the fault bit.
  pms_latch_flag #(
    .SET_VAL (1'h1),
    .RST_VAL (1'h0)
  ) u_rf (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .event_live (evt.lcw_valid && evt.lcw_rf),
    .follow     (st_ff.partner_rf),
    .rd_clr     (rd_clr),
    .force_clr  (1'h0),
    .flag_ff    (rf_flag_ff)
  );

  // Link status: any drop is held low until read.
  pms_latch_flag #(
    .SET_VAL (1'h0),
    .RST_VAL (1'h0)
  ) u_link (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .event_live (!evt.link_valid),
    .follow     (evt.link_valid),
    .rd_clr     (rd_clr),
    .force_clr  (1'h0),
    .flag_ff    (link_flag_ff)
  );

  // Jabber detect: detection is off while the inhibit control is zero.
  pms_latch_flag #(
    .SET_VAL (1'h1),
    .RST_VAL (1'h0)
  ) u_jab (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .event_live (evt.jabber_det),
    .follow     (1'h0),
    .rd_clr     (rd_clr),
    .force_clr  (!evt.jabber_inhibit),
    .flag_ff    (jab_flag_ff)
  );

  // Assembles the register image from constants, capabilities and the latched flags.
  always_comb begin
    status_word                            = 16'h0000;
    status_word[PMS_B_T4]                  = PMS_T4_VAL;
    status_word[PMS_B_TX_FD]               = st_ff.caps.tx_fd;
    status_word[PMS_B_TX_HD]               = st_ff.caps.tx_hd;
    status_word[PMS_B_T_FD]                = st_ff.caps.t_fd;
    status_word[PMS_B_T_HD]                = st_ff.caps.t_hd;
    status_word[PMS_B_RSV_HI:PMS_B_RSV_LO] = {4{PMS_RSV_VAL}};
    status_word[PMS_B_PRE]                 = st_ff.caps.pre_ok;
    status_word[PMS_B_ANC]                 = anc_flag_ff;
    status_word[PMS_B_RF]                  = rf_flag_ff;
    status_word[PMS_B_ANA]                 = PMS_ANA_VAL;
    status_word[PMS_B_LINK]                = link_flag_ff;
    status_word[PMS_B_JAB]                 = jab_flag_ff;
    status_word[PMS_B_EXT]                 = PMS_EXT_VAL;
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rd_valid = 1'h0;
    // The read image is taken from the flags before the clearing edge.
    if (rd_status) begin
      nxt_st.rd_data  = status_word;
      nxt_st.rd_valid = 1'h1;
    end else if (rd_detail) begin
      nxt_st.rd_data            = 16'h0000;
      nxt_st.rd_data[PMS_D_LINK] = link_flag_ff;
      nxt_st.rd_data[PMS_D_RF]   = rf_flag_ff;
      nxt_st.rd_data[PMS_D_JAB]  = jab_flag_ff;
      nxt_st.rd_valid            = 1'h1;
    end
    // Capability bits accept writes only under the override enable; reserved bits are dropped.
    if (wr_status && evt.override_en) begin
      nxt_st.caps.tx_fd  = req.wdata[PMS_B_TX_FD];
      nxt_st.caps.tx_hd  = req.wdata[PMS_B_TX_HD];
      nxt_st.caps.t_fd   = req.wdata[PMS_B_T_FD];
      nxt_st.caps.t_hd   = req.wdata[PMS_B_T_HD];
      nxt_st.caps.pre_ok = req.wdata[PMS_B_PRE];
    end
    if (evt.lcw_valid) begin
      nxt_st.partner_rf = evt.lcw_rf;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{caps: PMS_CAPS_RST, rd_data: 16'h0000, rd_valid: 1'h0, partner_rf: 1'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_ff      = st_ff.rd_data;
  assign rd_valid_ff     = st_ff.rd_valid;
  assign detail_flags_ff = {jab_flag_ff, rf_flag_ff, link_flag_ff};
  assign partner_rf_ff   = st_ff.partner_rf;
  assign preamble_ok_ff  = st_ff.caps.pre_ok;
  assign an_complete_ff  = anc_flag_ff;

  override_block_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_status && !evt.override_en) |=> $stable(st_ff.caps))
    else $error("capability bits changed without override");

  full_duplex_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_status && evt.override_en) |=> (st_ff.caps.t_fd == $past(req.wdata[PMS_B_T_FD])))
    else $error("bit 12 did not take the override write");

  half_duplex_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_status && evt.override_en) |=> (st_ff.caps.t_hd == $past(req.wdata[PMS_B_T_HD])))
    else $error("bit 11 did not take the override write");

  preamble_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wr_status && evt.override_en) |=> (preamble_ok_ff == $past(req.wdata[PMS_B_PRE])))
    else $error("preamble acceptance did not follow the write");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($past(rd_status) && rd_valid_ff) |-> (rd_data_ff[PMS_B_RSV_HI:PMS_B_RSV_LO] == 4'h0))
    else $error("reserved bits read nonzero");

  fixed_bits_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($past(rd_status) && rd_valid_ff) |-> (rd_data_ff[PMS_B_T4] == 1'h0))
    else $error("four-pair bit read nonzero");

  an_ability_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($past(rd_status) && rd_valid_ff) |-> (rd_data_ff[PMS_B_ANA] == 1'h1))
    else $error("negotiation ability bit read zero");

  ext_cap_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($past(rd_status) && rd_valid_ff) |-> (rd_data_ff[PMS_B_EXT] == 1'h1))
    else $error("extended capability bit read zero");

  pre_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_PRE] == $past(st_ff.caps.pre_ok)))
    else $error("bit 6 read differs from stored value");

  an_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !evt.an_enable |=> (anc_flag_ff == 1'h0))
    else $error("complete flag set while negotiation off");

  an_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(anc_flag_ff) |-> $past(evt.an_enable && evt.an_done))
    else $error("complete flag rose without completion");

  an_latch_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (anc_flag_ff && evt.an_enable && !rd_clr) |=> anc_flag_ff)
    else $error("complete flag dropped without a read");

  rf_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.lcw_valid && evt.lcw_rf) |=> (rf_flag_ff && detail_flags_ff[PMS_D_RF]))
    else $error("remote fault flag missed a code word");

  rf_copy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    evt.lcw_valid |=> (partner_rf_ff == $past(evt.lcw_rf)))
    else $error("remote fault copy not refreshed");

  rf_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_detail && !evt.lcw_valid && !st_ff.partner_rf) |=> !rf_flag_ff)
    else $error("detailed read did not clear remote fault");

  link_drop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !evt.link_valid ##1 !rd_clr |=> (link_flag_ff == 1'h0))
    else $error("link drop not held low");

  jab_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !evt.jabber_inhibit |=> (jab_flag_ff == 1'h0))
    else $error("jabber flag set while detection off");

  jab_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.jabber_inhibit && evt.jabber_det) |=> jab_flag_ff)
    else $error("jabber flag missed a jabber condition");

  jab_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_status && !evt.jabber_det) |=> !jab_flag_ff)
    else $error("status read did not clear jabber flag");

  read_latched_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_status && jab_flag_ff && evt.jabber_inhibit) |=> (rd_data_ff[PMS_B_JAB] && rd_valid_ff))
    else $error("read did not report the latched jabber value");

  read_valid_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_status || rd_detail) |=> rd_valid_ff)
    else $error("read gave no valid pulse");

  idle_valid_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(rd_status || rd_detail) |=> !rd_valid_ff)
    else $error("valid pulse without a read");

  read_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(rd_status || rd_detail) |=> $stable(rd_data_ff))
    else $error("read data changed without a read");

  caps_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_status |=> $stable(st_ff.caps))
    else $error("capability bits changed without a write");

  full_duplex_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_T_FD] == $past(st_ff.caps.t_fd)))
    else $error("bit 12 read differs from stored value");

  half_duplex_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_T_HD] == $past(st_ff.caps.t_hd)))
    else $error("bit 11 read differs from stored value");

  full_duplex_rst_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(arst_n) |-> (st_ff.caps.t_fd == PMS_CAPS_RST.t_fd))
    else $error("bit 12 left reset at the wrong value");

  half_duplex_rst_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(arst_n) |-> (st_ff.caps.t_hd == PMS_CAPS_RST.t_hd))
    else $error("bit 11 left reset at the wrong value");

  preamble_rst_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(arst_n) |-> (preamble_ok_ff == PMS_CAPS_RST.pre_ok))
    else $error("bit 6 left reset at the wrong value");

  detail_upper_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_detail |=> ((rd_data_ff >> (PMS_D_JAB + 1)) == 16'h0000))
    else $error("detailed read showed bits beyond the mirrors");

  rf_status_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_RF] == $past(rf_flag_ff)))
    else $error("bit 4 read differs from the flag");

  rf_detail_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_detail |=> (rd_data_ff[PMS_D_RF] == $past(rf_flag_ff)))
    else $error("detailed remote fault differs from the flag");

  link_status_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_LINK] == $past(link_flag_ff)))
    else $error("bit 2 read differs from the flag");

  link_detail_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_detail |=> (rd_data_ff[PMS_D_LINK] == $past(link_flag_ff)))
    else $error("detailed link status differs from the flag");

  jab_detail_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_detail |=> (rd_data_ff[PMS_D_JAB] == $past(jab_flag_ff)))
    else $error("detailed jabber differs from the flag");

  anc_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd_status |=> (rd_data_ff[PMS_B_ANC] == $past(anc_flag_ff)))
    else $error("bit 5 read differs from the flag");

  anc_present_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_clr && evt.an_enable && !evt.an_done) |=> !anc_flag_ff)
    else $error("complete flag kept after read without completion");

  link_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_clr && evt.link_valid) |=> link_flag_ff)
    else $error("link flag did not follow a valid link after read");

  rf_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_clr && !(evt.lcw_valid && evt.lcw_rf)) |=> (rf_flag_ff == $past(st_ff.partner_rf)))
    else $error("remote fault flag did not follow its copy after read");

  jab_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (jab_flag_ff && evt.jabber_inhibit && !rd_clr) |=> jab_flag_ff)
    else $error("jabber flag dropped without a read");

  link_low_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!link_flag_ff && !rd_clr) |=> !link_flag_ff)
    else $error("link flag rose without a read");

  rf_copy_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !evt.lcw_valid |=> $stable(partner_rf_ff))
    else $error("remote fault copy changed without a code word");

  rf_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(rf_flag_ff) |-> $past(evt.lcw_valid && evt.lcw_rf))
    else $error("remote fault flag rose without a faulted code word");

  jab_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(jab_flag_ff) |-> $past(evt.jabber_inhibit && evt.jabber_det))
    else $error("jabber flag rose without a jabber condition");

endmodule

/* sim/pms_sta_model.sv */
// Station management controller model that issues register reads and writes.
`timescale 1ns/10ps

module pms_sta_model
  import pms_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] rd_data_ff,
  input  wire logic        rd_valid_ff,
  output pms_req_t         req
);
  initial begin
    req = '0;
  end

  // Reserved bits 10..7 go out at zero while the write is asserted; the data is inverted once the write drops.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    req.wr    = 1'h1;
    req.addr  = a;
    req.wdata = d & 16'hF87F;
    @(negedge clk_sys);
    req.wr    = 1'h0;
    req.wdata = ~req.wdata;
  endtask

  // The answer is taken at the first falling edge after the read edge.
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_sys);
    req.rd   = 1'h1;
    req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'h0;
    v      = rd_valid_ff;
    d      = rd_data_ff;
  endtask
endmodule

/* sim/pms_status_reg_tb_top.sv */
// Self-checking testbench of the management status register bank.
`timescale 1ns/10ps

module pms_status_reg_tb_top
  import pms_pkg::*;
;
  logic        clk_sys;
  logic        arst_n;
  pms_req_t    req;
  pms_evt_t    evt;
  logic [15:0] rd_data_ff;
  logic        rd_valid_ff;
  logic [2:0]  detail_flags_ff;
  logic        partner_rf_ff;
  logic        preamble_ok_ff;
  logic        an_complete_ff;
  int          num_errors;
  int          n_checks;

  pms_status_reg dut_u (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .req             (req),
    .evt             (evt),
    .rd_data_ff      (rd_data_ff),
    .rd_valid_ff     (rd_valid_ff),
    .detail_flags_ff (detail_flags_ff),
    .partner_rf_ff   (partner_rf_ff),
    .preamble_ok_ff  (preamble_ok_ff),
    .an_complete_ff  (an_complete_ff)
  );

  pms_sta_model sta_u (
    .clk_sys     (clk_sys),
    .rd_data_ff  (rd_data_ff),
    .rd_valid_ff (rd_valid_ff),
    .req         (req)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    sta_u.rd(a, d, v);
    check(16'(v), 16'h0001);
    check(d, exp);
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic t_reset();
    rc(PMS_REG_STATUS, 16'h7809);
    rc(PMS_REG_STATUS, 16'h780D);
  endtask

  task automatic t_override();
    sta_u.wr(PMS_REG_STATUS, 16'h0000);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.override_en = 1'h1;
    sta_u.wr(PMS_REG_STATUS, 16'h0040);
    rc(PMS_REG_STATUS, 16'h004D);
    check(16'(preamble_ok_ff), 16'h0001);
    sta_u.wr(PMS_REG_STATUS, 16'h7800);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.override_en = 1'h0;
  endtask

  task automatic t_link();
    step(1);
    evt.link_valid = 1'h0;
    step(1);
    evt.link_valid = 1'h1;
    check(16'(detail_flags_ff), 16'h0000);
    rc(PMS_REG_STATUS, 16'h7809);
    rc(PMS_REG_STATUS, 16'h780D);
  endtask

  task automatic t_jabber();
    step(1);
    evt.jabber_det = 1'h1;
    step(1);
    evt.jabber_det = 1'h0;
    step(1);
    check(16'(detail_flags_ff), 16'h0005);
    rc(PMS_REG_DETAIL, 16'h0005);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.jabber_inhibit = 1'h0;
    evt.jabber_det     = 1'h1;
    step(2);
    check(16'(detail_flags_ff), 16'h0001);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.jabber_det     = 1'h0;
    evt.jabber_inhibit = 1'h1;
  endtask

  task automatic t_fault();
    step(1);
    evt.lcw_valid = 1'h1;
    evt.lcw_rf    = 1'h1;
    step(1);
    evt.lcw_valid = 1'h0;
    check(16'(partner_rf_ff), 16'h0001);
    rc(PMS_REG_STATUS, 16'h781D);
    rc(PMS_REG_DETAIL, 16'h0003);
    evt.lcw_valid = 1'h1;
    evt.lcw_rf    = 1'h0;
    step(1);
    evt.lcw_valid = 1'h0;
    check(16'(partner_rf_ff), 16'h0000);
    rc(PMS_REG_DETAIL, 16'h0003);
    rc(PMS_REG_STATUS, 16'h780D);
  endtask

  task automatic t_negotiation();
    evt.an_done = 1'h1;
    step(2);
    check(16'(an_complete_ff), 16'h0000);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.an_enable = 1'h1;
    evt.an_done   = 1'h0;
    step(2);
    check(16'(an_complete_ff), 16'h0000);
    evt.an_done = 1'h1;
    step(2);
    check(16'(an_complete_ff), 16'h0001);
    evt.an_done = 1'h0;
    step(2);
    check(16'(an_complete_ff), 16'h0001);
    rc(PMS_REG_STATUS, 16'h782D);
    rc(PMS_REG_STATUS, 16'h780D);
    evt.an_enable = 1'h0;
  endtask

  // An unknown address, a write to the detailed register and an event inside the read cycle.
  task automatic t_edge();
    logic [15:0] d;
    logic        v;
    sta_u.rd(5'h05, d, v);
    check(16'(v), 16'h0000);
    evt.override_en = 1'h1;
    sta_u.wr(PMS_REG_DETAIL, 16'h0000);
    evt.override_en = 1'h0;
    rc(PMS_REG_STATUS, 16'h780D);
    evt.jabber_det = 1'h1;
    rc(PMS_REG_STATUS, 16'h780F);
    evt.jabber_det = 1'h0;
    rc(PMS_REG_DETAIL, 16'h0005);
    rc(PMS_REG_STATUS, 16'h780D);
  endtask

  // A reset in mid-run brings overridden capability bits back to their defaults.
  task automatic t_rerst();
    evt.override_en = 1'h1;
    sta_u.wr(PMS_REG_STATUS, 16'h0040);
    evt.override_en = 1'h0;
    check(16'(preamble_ok_ff), 16'h0001);
    arst_n = 1'h0;
    step(2);
    arst_n = 1'h1;
    check(16'(preamble_ok_ff), 16'h0000);
    rc(PMS_REG_STATUS, 16'h7809);
    rc(PMS_REG_STATUS, 16'h780D);
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end

  initial begin
    clk_sys    = 1'h0;
    arst_n     = 1'h0;
    num_errors = 0;
    n_checks   = 0;
    evt        = '0;
    evt.link_valid     = 1'h1;
    evt.jabber_inhibit = 1'h1;
    step(5);
    arst_n = 1'h1;
    t_reset();
    t_override();
    t_link();
    t_jabber();
    t_fault();
    t_negotiation();
    t_edge();
    t_rerst();
    step(2);
    print_verdict();
  end
endmodule
